/* tmc_pkg.sv */
// Package: register map, field layout and mode codes for the timer mode control block
package tmc_pkg;
   localparam logic [11:0] TMC_OFF_MODE = 12'h000;
   localparam logic [11:0] TMC_OFF_CLKCTL = 12'h004;
   localparam logic [11:0] TMC_OFF_CNT0 = 12'h008;
   localparam logic [11:0] TMC_OFF_CNT1 = 12'h00c;
   localparam logic [11:0] TMC_OFF_CTRL = 12'h010;
   localparam int TMC_MODE_LO = 0;
   localparam int TMC_CT_SEL_BIT = 2;
   localparam int TMC_GATE_BIT = 3;
   localparam int TMC_T1_MODE_LO = 4;
   localparam int TMC_TIMEBASE_BIT = 3;
   localparam int TMC_RUN0_BIT = 0;
   localparam int TMC_RUN1_BIT = 1;
   localparam logic [7:0] TMC_MODE_RESET = 8'h00;
   localparam logic [7:0] TMC_CLKCTL_RESET = 8'h00;
   localparam logic [7:0] TMC_CTRL_RESET = 8'h00;
   localparam logic [3:0] TMC_DIV_SLOW = 4'hb;
   localparam logic [15:0] TMC_MASK13 = 16'h1fff;

   typedef enum logic [1:0] {
      TMC_M13 = 2'b00,
      TMC_M16 = 2'b01,
      TMC_M8AR = 2'b10,
      TMC_MSTOP = 2'b11
   } tmc_mode_t;

   typedef struct packed {
      logic ext_gate_enable_t0;
      logic counter_or_timer_select;
      tmc_mode_t first_timer_mode_field;
   } tmc_cfg_t;

   // Next count value for a mode; stopped mode holds
   function automatic logic [15:0] tmc_next_count(input tmc_mode_t m, input logic [15:0] c);
      logic [15:0] r;
      r = c;
      unique case (m)
         TMC_M13: r = (c + 16'h0001) & TMC_MASK13;
         TMC_M16: r = c + 16'h0001;
         TMC_M8AR: r = (c[7:0] == 8'hff) ? {c[15:8], c[15:8]} : {c[15:8], c[7:0] + 8'h01};
         TMC_MSTOP: r = c;
      endcase
      return r;
   endfunction
endpackage

/* tmc_sync.sv */
// Three-stage pin synchroniser with agreement filter and falling-edge pulse
`timescale 1ns/1ns
module tmc_sync
   import tmc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic fall
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Level only moves once stages two and three agree
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         level <= 1'b1;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end

   assign fall = level & (s2 == s3) & ~s3;
endmodule

/* tmc_prescale.sv */
// Divider giving one-cycle tick enables for the timer timebase
`timescale 1ns/1ns
module tmc_prescale
   import tmc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   output logic tick_slow
);
   logic [3:0] cnt;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt <= 4'h0;
         tick_slow <= 1'b0;
      end else begin
         tick_slow <= (cnt == TMC_DIV_SLOW);
         cnt <= (cnt == TMC_DIV_SLOW) ? 4'h0 : cnt + 4'h1;
      end
   end
endmodule

/* tmc_top.sv */
// Timer mode control: APB registers, gating, clock source and mode-dependent counting
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module tmc_top
   import tmc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_interrupt_zero_pin,
   input wire logic external_count_pin,
   output logic t0_enabled,
   output logic t0_inc,
   output logic [15:0] t0_count,
   output logic [15:0] t1_count
);
   logic [7:0] timer_mode_config;
   logic [7:0] clock_control_reg;
   logic [7:0] run_ctrl;
   logic ext_interrupt_zero_pin_level;
   logic cnt_fall;
   logic tick_slow;
   logic wr_en;
   logic known;
   logic cnt0_wr;
   logic cnt1_wr;
   tmc_cfg_t cfg;
   tmc_mode_t t1_mode;
   logic run_control_first_timer;
   logic timebase_select_bit;
   logic t0_src;
   logic next_t0_enabled;

   tmc_sync u_ext_interrupt_zero_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(ext_interrupt_zero_pin),
      .level(ext_interrupt_zero_pin_level),
      .fall()
   );

   tmc_sync u_cnt_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin(external_count_pin),
      .level(),
      .fall(cnt_fall)
   );

   tmc_prescale u_prescale (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick_slow(tick_slow)
   );

   // Zero-wait slave: access completes in the first access cycle
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign known = (paddr == TMC_OFF_MODE) | (paddr == TMC_OFF_CLKCTL) |
      (paddr == TMC_OFF_CNT0) | (paddr == TMC_OFF_CNT1) | (paddr == TMC_OFF_CTRL);
   assign pslverr = psel & penable & ~known;
   assign cnt0_wr = wr_en & (paddr == TMC_OFF_CNT0);
   assign cnt1_wr = wr_en & (paddr == TMC_OFF_CNT1);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         timer_mode_config <= TMC_MODE_RESET;
         clock_control_reg <= TMC_CLKCTL_RESET;
         run_ctrl <= TMC_CTRL_RESET;
      end else if (wr_en) begin
         if (paddr == TMC_OFF_MODE) begin
            timer_mode_config <= pwdata[7:0];
         end
         if (paddr == TMC_OFF_CLKCTL) begin
            clock_control_reg <= pwdata[7:0];
         end
         if (paddr == TMC_OFF_CTRL) begin
            run_ctrl <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel & ~penable & ~pwrite) begin
         unique case (paddr)
            TMC_OFF_MODE: prdata <= {24'h00_0000, timer_mode_config};
            TMC_OFF_CLKCTL: prdata <= {24'h00_0000, clock_control_reg};
            TMC_OFF_CNT0: prdata <= {16'h0000, t0_count};
            TMC_OFF_CNT1: prdata <= {16'h0000, t1_count};
            TMC_OFF_CTRL: prdata <= {24'h00_0000, run_ctrl};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign cfg.ext_gate_enable_t0 = timer_mode_config[TMC_GATE_BIT];
   assign cfg.counter_or_timer_select = timer_mode_config[TMC_CT_SEL_BIT];
   assign cfg.first_timer_mode_field =
      tmc_mode_t'(timer_mode_config[TMC_MODE_LO +: 2]);
   assign t1_mode = tmc_mode_t'(timer_mode_config[TMC_T1_MODE_LO +: 2]);
   assign run_control_first_timer = run_ctrl[TMC_RUN0_BIT];
   assign timebase_select_bit = clock_control_reg[TMC_TIMEBASE_BIT];

   // Gate: plain run bit, or run bit with pin high
   assign next_t0_enabled = run_control_first_timer &
      (~cfg.ext_gate_enable_t0 | ext_interrupt_zero_pin_level);

   // In timer mode the timebase bit picks full system rate or the divided tick; counter mode takes count-pin falls
   always_comb begin
      if (cfg.counter_or_timer_select) begin
         t0_src = cnt_fall;
      end else begin
         t0_src = timebase_select_bit ? 1'b1 : tick_slow;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         t0_enabled <= 1'b0;
         t0_inc <= 1'b0;
      end else begin
         t0_enabled <= next_t0_enabled;
         t0_inc <= next_t0_enabled & t0_src;
      end
   end

   // Timer 0 counts in whichever width its mode field selects
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         t0_count <= 16'h0000;
      end else if (cnt0_wr) begin
         t0_count <= pwdata[15:0];
      end else if (t0_inc) begin
         t0_count <= tmc_next_count(cfg.first_timer_mode_field, t0_count);
      end
   end

   // Timer 1 always counts on the divided tick, whatever the timebase bit; its mode 11 stops counting, but writes still load it
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         t1_count <= 16'h0000;
      end else if (cnt1_wr) begin
         t1_count <= pwdata[15:0];
      end else if (run_ctrl[TMC_RUN1_BIT] & tick_slow & (t1_mode != TMC_MSTOP)) begin
         t1_count <= tmc_next_count(t1_mode, t1_count);
      end
   end
endmodule

/* tmc_top_checker.sv */
// Checker for the timer mode control block, bound to its top module
`timescale 1ns/1ns
module tmc_top_checker
   import tmc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic ext_interrupt_zero_pin,
   input wire logic external_count_pin,
   input wire logic t0_enabled,
   input wire logic t0_inc,
   input wire logic [15:0] t0_count,
   input wire logic [15:0] t1_count
);
   logic [7:0] mcfg;
   logic [7:0] run;
   logic wr;
   logic w0;
   logic w1;
   assign wr = psel && penable && pwrite;
   assign w0 = wr && paddr == TMC_OFF_CNT0;
   assign w1 = wr && paddr == TMC_OFF_CNT1;
   // Shadow copies, so modes are judged without peeking inside
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mcfg <= 8'h00;
         run <= 8'h00;
      end else if (wr) begin
         if (paddr == TMC_OFF_MODE) mcfg <= pwdata[7:0];
         if (paddr == TMC_OFF_CTRL) run <= pwdata[7:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_m13; $changed(t0_count) && $past(mcfg[1:0] == 2'b00 && !w0)
      |-> t0_count == (($past(t0_count) + 16'h0001) & 16'h1fff); endproperty
   a_m13: assert property (p_m13) else $error("13-bit step wrong");
   property p_m16; $changed(t0_count) && $past(mcfg[1:0] == 2'b01 && !w0)
      |-> t0_count == $past(t0_count) + 16'h0001; endproperty
   a_m16: assert property (p_m16) else $error("16-bit step wrong");
   property p_m8; $changed(t0_count) && $past(mcfg[1:0] == 2'b10 && !w0)
      |-> t0_count[15:8] == $past(t0_count[15:8]) && t0_count[7:0] == ($past(t0_count[7:0])
      == 8'hff ? $past(t0_count[15:8]) : $past(t0_count[7:0]) + 8'h01); endproperty
   a_m8: assert property (p_m8) else $error("8-bit reload wrong");
   property p_t1stop; $past(mcfg[5:4] == 2'b11 && !w1) |-> $stable(t1_count); endproperty
   a_t1stop: assert property (p_t1stop) else $error("timer 1 moved");
   property p_t0stop; $past(mcfg[1:0] == 2'b11 && !w0) |-> $stable(t0_count); endproperty
   a_t0stop: assert property (p_t0stop) else $error("timer 0 moved");
   property p_nogate; (!mcfg[3] && run[0])[*3] |-> t0_enabled; endproperty
   a_nogate: assert property (p_nogate) else $error("run ignored");
   property p_gate; (mcfg[3] && !ext_interrupt_zero_pin)[*6] |-> !t0_enabled; endproperty
   a_gate: assert property (p_gate) else $error("gate ignored");
   property p_quiet; (mcfg[2] && external_count_pin)[*8] |-> !t0_inc; endproperty
   a_quiet: assert property (p_quiet) else $error("count without fall");
   property p_fall; $fell(external_count_pin) && mcfg[2] && t0_enabled |-> ##[2:8] t0_inc;
   endproperty
   a_fall: assert property (p_fall) else $error("fall not counted");
endmodule
bind tmc_top tmc_top_checker chk_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .ext_interrupt_zero_pin(ext_interrupt_zero_pin), .external_count_pin(external_count_pin),
   .t0_enabled(t0_enabled), .t0_inc(t0_inc), .t0_count(t0_count), .t1_count(t1_count));

/* tb_top.sv */
// Testbench for the timer mode control block
`timescale 1ns/1ns
module tb_top;
   import tmc_pkg::*;
   logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic ext_interrupt_zero_pin = 1, external_count_pin = 1, t0_enabled, t0_inc;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic err;
   logic [15:0] t0_count, t1_count, e;
   logic [15:0] pre [4] = '{16'h1ffe, 16'hfffd, 16'h40fd, 16'h1234};
   int fails = 0, total_checks = 0, incs = 0;
   tmc_top dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_interrupt_zero_pin(ext_interrupt_zero_pin), .external_count_pin(external_count_pin),
      .t0_enabled(t0_enabled), .t0_inc(t0_inc), .t0_count(t0_count), .t1_count(t1_count));
   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (t0_inc === 1'b1) incs <= incs + 1;
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      total_checks++;
      if (s !== x) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   // Idle cycle at the end keeps back-to-back calls from double-driving psel
   task automatic ap(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk_sys);
   endtask
   function automatic logic [15:0] stp(input int m, input logic [15:0] c);
      case (m)
         0: stp = (c + 16'h0001) & 16'h1fff;
         1: stp = c + 16'h0001;
         2: stp = (c[7:0] == 8'hff) ? {c[15:8], c[15:8]} : c + 16'h0001;
         default: stp = c;
      endcase
   endfunction
   task automatic end_of_test;
      if (fails == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #400000;
      fails++;
      end_of_test;
   end
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 0;
      @(posedge clk_sys);
      for (int i = 0; i < 6; i++) begin
         ap(12'(4 * i), 0, 0);
         chk("reset value", rd, 0);
         chk("pslverr", 32'(err), 32'(i == 5));
      end
      ap(TMC_OFF_CLKCTL, 1, 32'h8);
      for (int m = 0; m < 4; m++) begin
         ap(TMC_OFF_CNT0, 1, 32'(pre[m]));
         ap(TMC_OFF_CNT1, 1, 32'h55);
         ap(TMC_OFF_MODE, 1, 32'(m * 17));
         incs = 0;
         ap(TMC_OFF_CTRL, 1, 3);
         repeat (20) @(posedge clk_sys);
         ap(TMC_OFF_CTRL, 1, 0);
         repeat (8) @(posedge clk_sys);
         e = pre[m];
         repeat (incs) e = stp(m, e);
         ap(TMC_OFF_CNT0, 0, 0);
         chk("t0_count", rd, 32'(e));
         if (m == 1) chk("fast ticks", 32'(incs > 15), 1);
         ap(TMC_OFF_CNT1, 0, 0);
         if (m == 3) chk("t1_count", rd, 32'h55);
      end
      ap(TMC_OFF_CLKCTL, 1, 0);
      ap(TMC_OFF_MODE, 1, 1);
      incs = 0;
      ap(TMC_OFF_CTRL, 1, 1);
      repeat (48) @(posedge clk_sys);
      ap(TMC_OFF_CTRL, 1, 0);
      chk("slow ticks", 32'(incs > 2 && incs < 6), 1);
      ap(TMC_OFF_CTRL, 1, 1);
      for (int g = 0; g < 4; g++) begin
         ap(TMC_OFF_MODE, 1, 32'((g / 2) * 8));
         ext_interrupt_zero_pin <= g[0];
         repeat (8) @(posedge clk_sys);
         chk("t0_enabled", 32'(t0_enabled), 32'(g < 2 || g[0]));
      end
      ap(TMC_OFF_MODE, 1, 32'h4);
      // Let a last timer-mode pulse drain so clearing the tally cannot race it
      repeat (2) @(posedge clk_sys);
      incs = 0;
      repeat (3) begin
         external_count_pin <= 0;
         repeat (6) @(posedge clk_sys);
         external_count_pin <= 1;
         repeat (6) @(posedge clk_sys);
      end
      repeat (10) @(posedge clk_sys);
      chk("falls counted", 32'(incs), 3);
      end_of_test;
   end
endmodule
